// ### logic/io_ports_pkg.sv
// package: port register map, reset values and carrier types
package io_ports_pkg;
    localparam int port_width = 6;
    localparam logic [7:0] status_flags_addr = 8'h03;
    localparam logic [7:0] port_b_pins_addr = 8'h06;
    localparam logic [7:0] port_c_pins_addr = 8'h07;
    localparam logic [5:0] direction_reset = 6'h3F;
    localparam logic [7:0] option_reset = 8'hFF;
    localparam int wake_flag_bit = 7;
    localparam int timer_clock_source_bit = 5;
    localparam int input_only_bit = 3;
    localparam int timer_clock_bit = 5;
    localparam logic [7:0] direction_load_port_b = 8'h06;
    localparam logic [7:0] direction_load_port_c = 8'h07;

    // one port's pin-facing signals
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } pin_drive_t;

    // core access request for one cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_set;
        logic bit_clear;
        logic [2:0] bit_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } core_req_t;
endpackage

// ### logic/port_slice.sv
// module: one six-bit port, latches and direction
`timescale 1ns/1ps
module port_slice (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // core side
    input wire logic latch_we,
    input wire logic [5:0] latch_data,
    input wire logic dir_we,
    input wire logic [5:0] dir_data,
    // pin control
    input wire logic [5:0] digital_ok,
    input wire logic [5:0] no_driver,
    input wire logic [5:0] force_in,
    input wire logic [5:0] force_out,
    output io_ports_pkg::pin_drive_t drive
);
    typedef struct packed {
        logic [5:0] latch;
        logic [5:0] dir;
        io_ports_pkg::pin_drive_t drive;
    } slice_state_t;

    slice_state_t state;
    slice_state_t next_state;

    always_comb begin
        next_state = state;
        if (latch_we) begin
            next_state.latch = latch_data;
        end
        if (dir_we) begin
            next_state.dir = dir_data;
        end
        if (srst) begin
            // latch keeps its value across reset
            next_state.dir = io_ports_pkg::direction_reset;
        end
        next_state.drive.out = next_state.latch;
        // zero direction drives, one floats; alternates and input-only override
        next_state.drive.oe = ((~next_state.dir & ~force_in) | force_out)
            & digital_ok & ~no_driver;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state.dir <= io_ports_pkg::direction_reset;
            state.drive.oe <= 6'h00;
            state.latch <= next_state.latch;
            state.drive.out <= next_state.latch;
        end else begin
            state <= next_state;
        end
    end

    assign drive = state.drive;
endmodule

// ### logic/six_bit_io_ports.sv
// module: two six-bit general I/O ports, status wake flag
`timescale 1ns/1ps
//
// Function
// - port reads return six pin bits, upper two bits read zero
// - direction register loads from working register on direction-load instruction
// - direction one floats the pin, zero drives it from the latch
// - input-only pin never drives; timer clock pin follows clock source select
// - port read returns pin levels, never the latch contents
// - direction registers write-only, all ones on every reset
// - output latches hold until the port is written again
// - inputs pass two sync stages every cycle outside reset (stages clear during reset); reads see pins from two edges back
// - each pin except input-only has its own direction bit
// - digital I/O only when all higher-priority alternate functions disabled
// - oscillator pins have digital input disabled while oscillator selected
// - bit set/clear reads pins, modifies one bit, writes whole latch
// - writes update latches at cycle end; reads see pins sampled two edges earlier
// - status bit seven reads one only after pin-change wake reset
// - pins serving alternate functions read zero
module six_bit_io_ports (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // core access
    input io_ports_pkg::core_req_t req,
    input wire logic dir_load,
    input wire logic option_load,
    input wire logic [7:0] w_reg,
    input wire logic [6:0] status_low,
    output logic [7:0] rdata,
    // reset cause
    input wire logic reset_by_pin_wake,
    // alternate function enables per pin, one means alternate in use
    input wire logic [5:0] alt_b,
    input wire logic [5:0] alt_c,
    input wire logic [5:0] osc_b,
    input wire logic [5:0] osc_c,
    // pins
    input wire logic [5:0] pin_b_in,
    input wire logic [5:0] pin_c_in,
    output logic [5:0] pin_b_out,
    output logic [5:0] pin_b_oe,
    output logic [5:0] pin_c_out,
    output logic [5:0] pin_c_oe,
    // timer configuration
    output logic timer_clock_source_select
);
    typedef struct packed {
        logic [5:0] sync_b1;
        logic [5:0] sync_b2;
        logic [5:0] sync_c1;
        logic [5:0] sync_c2;
        logic [7:0] option;
        logic wake_flag;
        logic [7:0] rdata;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    logic [5:0] read_b;
    logic [5:0] read_c;
    logic b_hit;
    logic c_hit;
    logic b_latch_we;
    logic c_latch_we;
    logic [5:0] b_latch_data;
    logic [5:0] c_latch_data;
    logic [5:0] no_driver_b;
    logic [5:0] force_in_c;
    logic b_dir_we;
    logic c_dir_we;
    logic tcs;
    io_ports_pkg::pin_drive_t drive_b;
    io_ports_pkg::pin_drive_t drive_c;

    // visible pin value with alternates and oscillator inputs masked
    function automatic logic [5:0] pin_view(input logic [5:0] pins,
                                            input logic [5:0] alt,
                                            input logic [5:0] osc);
        pin_view = pins & ~alt & ~osc;
    endfunction

    // read-modify-write of one bit over the pin view
    function automatic logic [5:0] modify(input logic [5:0] view,
                                          input io_ports_pkg::core_req_t r);
        logic [7:0] v;
        v = {2'b00, view};
        if (r.bit_set) begin
            v[r.bit_sel] = 1'b1;
        end else if (r.bit_clear) begin
            v[r.bit_sel] = 1'b0;
        end else begin
            v = r.wdata;
        end
        modify = v[5:0];
    endfunction

    // a port latch takes a plain write or either bit operation aimed at it
    function automatic logic latch_write(input logic hit,
                                         input io_ports_pkg::core_req_t r);
        latch_write = hit & (r.wr | r.bit_set | r.bit_clear);
    endfunction

    // direction-load instruction naming one port
    function automatic logic dir_write(input logic load,
                                       input logic [7:0] addr,
                                       input logic [7:0] port_sel);
        dir_write = load & (addr == port_sel);
    endfunction

    assign tcs = state.option[io_ports_pkg::timer_clock_source_bit];
    // pin levels are seen two clock edges after they are sampled
    assign read_b = pin_view(state.sync_b2, alt_b, osc_b);
    assign read_c = pin_view(state.sync_c2, alt_c, osc_c);
    assign b_hit = (req.addr == io_ports_pkg::port_b_pins_addr);
    assign c_hit = (req.addr == io_ports_pkg::port_c_pins_addr);
    assign b_latch_we = latch_write(b_hit, req);
    assign c_latch_we = latch_write(c_hit, req);
    assign b_latch_data = modify(read_b, req);
    assign c_latch_data = modify(read_c, req);
    assign b_dir_we = dir_write(dir_load, req.addr, io_ports_pkg::direction_load_port_b);
    assign c_dir_we = dir_write(dir_load, req.addr, io_ports_pkg::direction_load_port_c);
    assign no_driver_b = 6'h01 << io_ports_pkg::input_only_bit;
    // timer clock source forces the timer clock pin to input
    assign force_in_c = tcs ? (6'h01 << io_ports_pkg::timer_clock_bit) : 6'h00;

    always_comb begin
        next_state = state;
        next_state.sync_b1 = pin_b_in;
        next_state.sync_b2 = state.sync_b1;
        next_state.sync_c1 = pin_c_in;
        next_state.sync_c2 = state.sync_c1;
        if (option_load) begin
            next_state.option = w_reg;
        end
        next_state.rdata = 8'h00;
        if (req.rd) begin
            if (b_hit) begin
                next_state.rdata = {2'b00, read_b};
            end else if (c_hit) begin
                next_state.rdata = {2'b00, read_c};
            end else if (req.addr == io_ports_pkg::status_flags_addr) begin
                next_state.rdata = {state.wake_flag, status_low};
            end
        end
        if (srst) begin
            next_state.option = io_ports_pkg::option_reset;
            next_state.wake_flag = reset_by_pin_wake;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state.sync_b1 <= 6'h00;
            state.sync_b2 <= 6'h00;
            state.sync_c1 <= 6'h00;
            state.sync_c2 <= 6'h00;
            state.option <= io_ports_pkg::option_reset;
            state.rdata <= 8'h00;
            // reset cause captured while reset is held
            state.wake_flag <= next_state.wake_flag;
        end else begin
            state <= next_state;
        end
    end

    port_slice u_port_b (
        .clk(clk),
        .srst(srst),
        .latch_we(b_latch_we),
        .latch_data(b_latch_data),
        .dir_we(b_dir_we),
        .dir_data(w_reg[5:0]),
        .digital_ok(~alt_b & ~osc_b),
        .no_driver(no_driver_b),
        .force_in(6'h00),
        .force_out(6'h00),
        .drive(drive_b)
    );

    port_slice u_port_c (
        .clk(clk),
        .srst(srst),
        .latch_we(c_latch_we),
        .latch_data(c_latch_data),
        .dir_we(c_dir_we),
        .dir_data(w_reg[5:0]),
        .digital_ok(~alt_c & ~osc_c),
        .no_driver(6'h00),
        .force_in(force_in_c),
        .force_out(6'h00),
        .drive(drive_c)
    );

    assign rdata = state.rdata;
    assign pin_b_out = drive_b.out;
    assign pin_b_oe = drive_b.oe;
    assign pin_c_out = drive_c.out;
    assign pin_c_oe = drive_c.oe;
    assign timer_clock_source_select = state.option[io_ports_pkg::timer_clock_source_bit];
endmodule

// ### bench/six_bit_io_ports_asserts.sv
// checker: timing and drive relations at the port block pins
`timescale 1ns/1ps
module six_bit_io_ports_asserts (
    input wire logic clk,
    input wire logic srst,
    input io_ports_pkg::core_req_t req,
    input wire logic dir_load,
    input wire logic [7:0] w_reg,
    input wire logic [6:0] status_low,
    input wire logic [7:0] rdata,
    input wire logic reset_by_pin_wake,
    input wire logic [5:0] alt_b,
    input wire logic [5:0] osc_b,
    input wire logic [5:0] pin_b_in,
    input wire logic [5:0] pin_b_out,
    input wire logic [5:0] pin_b_oe,
    input wire logic [5:0] pin_c_oe,
    input wire logic timer_clock_source_select
);
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic wake;
    always_ff @(posedge clk) if (srst) wake <= reset_by_pin_wake;
    sequence rd_b; req.rd && req.addr == 8'h06; endsequence
    sequence wr_b; req.wr && req.addr == 8'h06; endsequence
    sequence no_wr_b; !(req.wr || req.bit_set || req.bit_clear); endsequence
    sequence quiet_b; (alt_b == 6'h00 && osc_b == 6'h00 && $stable(pin_b_in))[*3]; endsequence
    AST_UPPER_ZERO: assert property (req.rd && req.addr != 8'h03 |=> rdata[7:6] == 2'b00)
        else $error("upper read bits not zero");
    AST_DIR_RESET: assert property ($fell(srst) |-> pin_b_oe == 6'h00 && pin_c_oe == 6'h00)
        else $error("driver on after reset");
    AST_IN_ONLY: assert property (pin_b_oe[3] == 1'b0)
        else $error("input-only pin driven");
    AST_TCS: assert property (timer_clock_source_select && $past(timer_clock_source_select)
        |-> !pin_c_oe[5])
        else $error("timer clock pin driven");
    AST_ALT: assert property ((pin_b_oe & $past(alt_b | osc_b)) == 6'h00)
        else $error("alternate pin driven");
    AST_READ_PINS: assert property (quiet_b ##0 rd_b |=> rdata[5:0] == $past(pin_b_in))
        else $error("read differs from pins");
    AST_WRITE: assert property (wr_b |=> pin_b_out == $past(req.wdata[5:0]))
        else $error("latch not written");
    AST_HOLD: assert property (wr_b ##1 no_wr_b [*3] |-> $stable(pin_b_out))
        else $error("latch changed without write");
    AST_DIR_LOAD: assert property (dir_load && req.addr == 8'h06 && (alt_b | osc_b) == 6'h00
        |=> pin_b_oe == (~$past(w_reg[5:0]) & 6'h37))
        else $error("direction load wrong");
    AST_WAKE: assert property (req.rd && req.addr == 8'h03
        |=> rdata == {wake, $past(status_low)})
        else $error("status read wrong");
endmodule
bind six_bit_io_ports six_bit_io_ports_asserts chk (.clk, .srst, .req, .dir_load, .w_reg,
    .status_low, .rdata, .reset_by_pin_wake, .alt_b, .osc_b, .pin_b_in, .pin_b_out,
    .pin_b_oe, .pin_c_oe, .timer_clock_source_select);

// ### bench/pin_world.sv
// model: external circuitry on the port pins
`timescale 1ns/1ps
module pin_world (
    // device drivers
    input wire logic [5:0] out_b,
    input wire logic [5:0] oe_b,
    input wire logic [5:0] out_c,
    input wire logic [5:0] oe_c,
    // external levels, clamp overrides a driven pin
    input wire logic [5:0] ext_b,
    input wire logic [5:0] ext_c,
    input wire logic [5:0] clamp_b,
    // pin levels
    output logic [5:0] pin_b,
    output logic [5:0] pin_c
);
    // ----------------
    // wire levels
    // ----------------
    assign pin_b = ((clamp_b | ~oe_b) & ext_b) | (~clamp_b & oe_b & out_b);
    assign pin_c = (~oe_c & ext_c) | (oe_c & out_c);
endmodule

// ### bench/six_bit_io_ports_tb_top.sv
// testbench: port block scenarios
`timescale 1ns/1ps
module six_bit_io_ports_tb_top;
    // ----------------
    // stimulus
    // ----------------
    localparam logic [5:0] k_rd = 6'h20, k_wr = 6'h10, k_clr = 6'h04, k_dir = 6'h02, k_opt = 6'h01;
    logic clk, srst, dir_load, option_load, reset_by_pin_wake, timer_clock_source_select;
    io_ports_pkg::core_req_t req;
    logic [7:0] w_reg, rdata;
    logic [6:0] status_low;
    logic [5:0] alt_b, alt_c, osc_b, osc_c, ext_b, ext_c, clamp_b, pin_b_in, pin_c_in;
    logic [5:0] pin_b_out, pin_b_oe, pin_c_out, pin_c_oe;
    int num_errors, n_checks;
    six_bit_io_ports DUT (.clk, .srst, .req, .dir_load, .option_load, .w_reg, .status_low,
        .rdata, .reset_by_pin_wake, .alt_b, .alt_c, .osc_b, .osc_c, .pin_b_in, .pin_c_in,
        .pin_b_out, .pin_b_oe, .pin_c_out, .pin_c_oe, .timer_clock_source_select);
    pin_world far (.out_b(pin_b_out), .oe_b(pin_b_oe), .out_c(pin_c_out), .oe_c(pin_c_oe),
        .ext_b, .ext_c, .clamp_b, .pin_b(pin_b_in), .pin_c(pin_c_in));
    task automatic stop_test;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic go(input logic [5:0] k, input logic [2:0] s, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk);
        req <= '{k[5], k[4], k[3], k[2], s, a, d};
        dir_load <= k[1];
        option_load <= k[0];
        w_reg <= d;
        @(posedge clk);
        req <= '0;
        dir_load <= 1'b0;
        option_load <= 1'b0;
        #1;
    endtask
    task automatic do_reset(input logic w);
        @(posedge clk);
        srst <= 1'b1;
        reset_by_pin_wake <= w;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        #1;
    endtask
    task automatic pins(input logic [5:0] b, input logic [5:0] c, input logic [5:0] cl);
        @(posedge clk);
        ext_b <= b;
        ext_c <= c;
        clamp_b <= cl;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_reset;
        go(k_wr, 3'h0, 8'h06, 8'h15);
        do_reset(1'b1);
        check("oe_b", 8'h00, {2'b00, pin_b_oe});
        check("out_b", 8'h15, {2'b00, pin_b_out});
        go(k_rd, 3'h0, 8'h03, 8'h00);
        check("status", {1'b1, status_low}, rdata);
        do_reset(1'b0);
        go(k_rd, 3'h0, 8'h03, 8'h00);
        check("status", {1'b0, status_low}, rdata);
    endtask
    task automatic t_drive;
        go(k_dir, 3'h0, 8'h06, 8'h00);
        check("oe_b", 8'h37, {2'b00, pin_b_oe});
        go(k_wr, 3'h0, 8'h06, 8'hEA);
        check("out_b", 8'h2A, {2'b00, pin_b_out});
        pins(6'h15, 6'h3F, 6'h3F);
        go(k_rd, 3'h0, 8'h06, 8'h00);
        check("rd_b", 8'h15, rdata);
        pins(6'h15, 6'h3F, 6'h00);
        go(k_rd, 3'h0, 8'h06, 8'h00);
        check("rd_b", 8'h22, rdata);
    endtask
    task automatic t_rmw;
        // bits 5:3 inputs, bits 2:0 driven
        go(k_dir, 3'h0, 8'h06, 8'h38);
        go(k_wr, 3'h0, 8'h06, 8'h00);
        pins(6'h38, 6'h3F, 6'h00);
        go(k_clr, 3'h5, 8'h06, 8'h00);
        check("out_b", 8'h18, {2'b00, pin_b_out});
        go(6'h08, 3'h0, 8'h06, 8'h00);
        check("out_b", 8'h39, {2'b00, pin_b_out});
    endtask
    task automatic t_alt;
        go(k_dir, 3'h0, 8'h06, 8'h00);
        @(posedge clk);
        alt_b <= 6'h01;
        osc_c <= 6'h02;
        // bit zero floats high, so only the alternate mask reads it low
        pins(6'h39, 6'h3F, 6'h00);
        go(k_rd, 3'h0, 8'h06, 8'h00);
        check("oe_b", 8'h36, {2'b00, pin_b_oe});
        check("rd_b", 8'h38, rdata);
        go(k_rd, 3'h0, 8'h07, 8'h00);
        check("rd_c", 8'h3D, rdata);
        @(posedge clk);
        alt_b <= 6'h00;
        osc_c <= 6'h00;
    endtask
    task automatic t_tcs;
        check("tcs", 8'h01, {7'h00, timer_clock_source_select});
        go(k_dir, 3'h0, 8'h07, 8'h00);
        check("oe_c", 8'h1F, {2'b00, pin_c_oe});
        go(k_opt, 3'h0, 8'h00, 8'h00);
        @(posedge clk);
        #1;
        check("oe_c", 8'h3F, {2'b00, pin_c_oe});
        check("tcs", 8'h00, {7'h00, timer_clock_source_select});
        go(k_wr, 3'h0, 8'h07, 8'hED);
        check("out_c", 8'h2D, {2'b00, pin_c_out});
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        {srst, reset_by_pin_wake, dir_load, option_load, req, w_reg} = '0;
        srst = 1'b1;
        status_low = 7'h2B;
        {alt_b, alt_c, osc_b, osc_c, ext_b, ext_c, clamp_b} = '0;
        do_reset(1'b0);
        t_reset();
        t_drive();
        t_rmw();
        t_alt();
        t_tcs();
        stop_test();
    end
endmodule
